// [hdl/fpled_pkg.sv]
/*
  package for the front panel led status block: register offsets, fields,
  reset values, step codes and blink timing.
  assumes a 100 MHz system clock and a plain strobe register port.
*/
// Function
// - hot swap led: on, short, long blink
// - fault led lit while fault exists
// - user led lit when powered, no fault
// - power good lit only when supplies ok
// - config led: off, slow blink, on
// - fpga led dark when not configured
// - config controller owns leds before configuration
// - codes 0 idle, 1 sysclk, 2 userclk
// - codes 3 oscillator, 4 crosspoint, 5 distribution
// - codes 6 to 9 converters A to D
// - fpga drives leds after config; status default
// - led1 lit while any acquire unit busy
// - led2 lit when both memory controllers calibrated
// - led3 lit when all converter channels calibrated
// - led4 keep-alive while host bus running
// - user mode: leds follow software values
`default_nettype none
package fpled_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_LEDS   = 4'h8;

  // control register fields
  localparam int unsigned CTRL_USER_BIT = 0;
  localparam int unsigned CTRL_VAL_LSB  = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  // initialization step codes shown before configuration
  localparam logic [3:0] STEP_IDLE     = 4'h0;
  localparam logic [3:0] STEP_SYSCLK   = 4'h1;
  localparam logic [3:0] STEP_USERCLK  = 4'h2;
  localparam logic [3:0] STEP_OSC      = 4'h3;
  localparam logic [3:0] STEP_XPOINT   = 4'h4;
  localparam logic [3:0] STEP_CLKDIST  = 4'h5;
  localparam logic [3:0] STEP_CONV_A   = 4'h6;
  localparam logic [3:0] STEP_CONV_B   = 4'h7;
  localparam logic [3:0] STEP_CONV_C   = 4'h8;
  localparam logic [3:0] STEP_CONV_D   = 4'h9;

  // blink half periods
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SHORT_MS      = 100;
  localparam int unsigned LONG_MS       = 500;
  localparam int unsigned SLOW_MS       = 1000;
  localparam int unsigned ALIVE_MS      = 250;
  localparam int unsigned SHORT_CYC = (CLK_HZ / 1000) * SHORT_MS;
  localparam int unsigned LONG_CYC  = (CLK_HZ / 1000) * LONG_MS;
  localparam int unsigned SLOW_CYC  = (CLK_HZ / 1000) * SLOW_MS;
  localparam int unsigned ALIVE_CYC = (CLK_HZ / 1000) * ALIVE_MS;

  // hot swap indicator requests
  typedef enum logic [3:0] {
    FPLED_SWAP_OFF   = 4'b0001,
    FPLED_SWAP_ON    = 4'b0010,
    FPLED_SWAP_SHORT = 4'b0100,
    FPLED_SWAP_LONG  = 4'b1000
  } fpled_swap_t;

  // board configuration phases
  typedef enum logic [2:0] {
    FPLED_CFG_WAIT = 3'b001,
    FPLED_CFG_BUSY = 3'b010,
    FPLED_CFG_DONE = 3'b100
  } fpled_cfg_t;

  // status sources
  typedef struct packed {
    logic [3:0] unit_busy;
    logic [1:0] mem_cal_ok;
    logic [3:0] conv_cal_ok;
    logic       host_alive;
  } fpled_src_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fpled_bus_t;

  // board panel lamps
  typedef struct packed {
    logic hot_swap;
    logic fault;
    logic user;
    logic power_good;
    logic board_cfg;
    logic fpga;
  } fpled_panel_t;

endpackage
`default_nettype wire

// [hdl/fpled_blink.sv]
/*
  free-running square wave divider: toggles every HALF clock cycles.
  assumes one clock domain and the asynchronous active-high reset.
*/
`default_nettype none
module fpled_blink #(
  parameter int unsigned HALF = 1000
) (
  input  wire logic clk,
  input  wire logic rst,
  output var  logic wave
);

  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_reg;
  logic          wave_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      wave_reg <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg  <= '0;
      wave_reg <= ~wave_reg;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
    end
  end

  assign wave = wave_reg;

endmodule
`default_nettype wire

// [hdl/fpled_top.sv]
/*
  front panel led status: hot swap, fault, user, power good, board config
  and fpga lamps, plus four general leds with step code, status and user
  modes. status inputs come from the same clock domain except the pins
  named *_pin, which are synchronised here. registers on a strobe port.
*/
// The implementer's own choices: the plain strobed port and the register addresses.
`default_nettype none
module fpled_top #(
  parameter int unsigned SHORT_HALF = fpled_pkg::SHORT_CYC,
  parameter int unsigned LONG_HALF  = fpled_pkg::LONG_CYC,
  parameter int unsigned SLOW_HALF  = fpled_pkg::SLOW_CYC,
  parameter int unsigned ALIVE_HALF = fpled_pkg::ALIVE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire fpled_pkg::fpled_bus_t     bus,
  output var  logic [fpled_pkg::DATA_W-1:0] rdata,
  input  wire fpled_pkg::fpled_swap_t    swap_req_pin,
  input  wire logic                      fault_pin,
  input  wire logic                      payload_pwr_pin,
  input  wire logic                      supplies_ok_pin,
  input  wire logic                      board_cfg_done_pin,
  input  wire logic                      fpga_cfg_done_pin,
  input  wire logic [3:0]                step_code_pin,
  input  wire fpled_pkg::fpled_src_t     src,
  output var  fpled_pkg::fpled_panel_t   panel,
  output var  logic [3:0]                gen_led
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int unsigned SW = 4 + 5 + 4;

  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;

  assign pin_raw = {swap_req_pin, fault_pin, payload_pwr_pin, supplies_ok_pin,
                    board_cfg_done_pin, fpga_cfg_done_pin, step_code_pin};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic [3:0] swap_req;
  logic       fault_s;
  logic       pwr_s;
  logic       ok_s;
  logic       bcfg_s;
  logic       fcfg_s;
  logic [3:0] step_s;

  assign swap_req = sync2_reg[12:9];
  assign fault_s = sync2_reg[8];
  assign pwr_s   = sync2_reg[7];
  assign ok_s    = sync2_reg[6];
  assign bcfg_s  = sync2_reg[5];
  assign fcfg_s  = sync2_reg[4];
  assign step_s  = sync2_reg[3:0];

  //////////////////////////////////////////////////////////////////////////
  // blink sources

  logic short_w;
  logic long_w;
  logic slow_w;
  logic alive_w;

  fpled_blink #(.HALF(SHORT_HALF)) u_short (
    .clk  (clk),
    .rst  (rst),
    .wave (short_w)
  );

  fpled_blink #(.HALF(LONG_HALF)) u_long (
    .clk  (clk),
    .rst  (rst),
    .wave (long_w)
  );

  fpled_blink #(.HALF(SLOW_HALF)) u_slow (
    .clk  (clk),
    .rst  (rst),
    .wave (slow_w)
  );

  fpled_blink #(.HALF(ALIVE_HALF)) u_alive (
    .clk  (clk),
    .rst  (rst),
    .wave (alive_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // control register

  logic [fpled_pkg::DATA_W-1:0] ctrl_reg;
  logic                         user_mode;
  logic [3:0]                   user_val;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= fpled_pkg::CTRL_RESET;
    end else if (bus.wr && bus.addr == fpled_pkg::OFF_CTRL) begin
      ctrl_reg <= bus.wdata & 32'h0000_00F1;
    end
  end

  assign user_mode = ctrl_reg[fpled_pkg::CTRL_USER_BIT];
  assign user_val  = ctrl_reg[fpled_pkg::CTRL_VAL_LSB +: 4];

  //////////////////////////////////////////////////////////////////////////
  // board configuration phase

  fpled_pkg::fpled_cfg_t cfg_state;

  always_comb begin
    if (!pwr_s || !ok_s) begin
      cfg_state = fpled_pkg::FPLED_CFG_WAIT;
    end else if (!bcfg_s) begin
      cfg_state = fpled_pkg::FPLED_CFG_BUSY;
    end else begin
      cfg_state = fpled_pkg::FPLED_CFG_DONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // panel lamps

  fpled_pkg::fpled_panel_t panel_next;
  fpled_pkg::fpled_panel_t panel_reg;

  always_comb begin
    panel_next = '0;
    unique case (swap_req)
      fpled_pkg::FPLED_SWAP_ON:    panel_next.hot_swap = 1'b1;
      fpled_pkg::FPLED_SWAP_SHORT: panel_next.hot_swap = short_w;
      fpled_pkg::FPLED_SWAP_LONG:  panel_next.hot_swap = long_w;
      fpled_pkg::FPLED_SWAP_OFF:   panel_next.hot_swap = 1'b0;
      default:                   panel_next.hot_swap = 1'b0;
    endcase
    panel_next.fault      = fault_s;
    panel_next.user       = pwr_s && !fault_s;
    panel_next.power_good = pwr_s && ok_s;
    unique case (cfg_state)
      fpled_pkg::FPLED_CFG_WAIT: panel_next.board_cfg = 1'b0;
      fpled_pkg::FPLED_CFG_BUSY: panel_next.board_cfg = slow_w;
      fpled_pkg::FPLED_CFG_DONE: panel_next.board_cfg = 1'b1;
    endcase
    panel_next.fpga       = fcfg_s;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      panel_reg <= '0;
    end else begin
      panel_reg <= panel_next;
    end
  end

  assign panel = panel_reg;

  //////////////////////////////////////////////////////////////////////////
  // general leds

  function automatic logic [3:0] step_clip(input logic [3:0] code);
    // codes beyond the converter steps read as idle
    if (code > fpled_pkg::STEP_CONV_D) begin
      step_clip = fpled_pkg::STEP_IDLE;
    end else begin
      step_clip = code;
    end
  endfunction

  logic [3:0] status_val;
  logic [3:0] gen_next;
  logic [3:0] gen_reg;
  logic       owned;

  assign owned = bcfg_s && fcfg_s;

  always_comb begin
    status_val[0] = |src.unit_busy;
    status_val[1] = &src.mem_cal_ok;
    status_val[2] = &src.conv_cal_ok;
    status_val[3] = src.host_alive && alive_w;
  end

  always_comb begin
    if (!owned) begin
      gen_next = step_clip(step_s);
    end else if (user_mode) begin
      gen_next = user_val;
    end else begin
      gen_next = status_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_reg <= fpled_pkg::STEP_IDLE;
    end else begin
      gen_reg <= gen_next;
    end
  end

  assign gen_led = gen_reg;

  //////////////////////////////////////////////////////////////////////////
  // read port

  logic [fpled_pkg::DATA_W-1:0] rdata_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        fpled_pkg::OFF_CTRL:   rdata_reg <= ctrl_reg;
        fpled_pkg::OFF_STATUS: rdata_reg <= {26'h0, panel_reg};
        fpled_pkg::OFF_LEDS:   rdata_reg <= {27'h0, owned, gen_reg};
        default:               rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;

endmodule
`default_nettype wire

// [test/fpled_props.sv]
/* port checker for fpled_top.
   assumes one clock and rst async active high. */
`default_nettype none
module fpled_props (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire fpled_pkg::fpled_bus_t   bus,
  input wire fpled_pkg::fpled_swap_t  swap_req_pin,
  input wire logic                    fault_pin,
  input wire logic                    payload_pwr_pin,
  input wire logic                    supplies_ok_pin,
  input wire logic                    board_cfg_done_pin,
  input wire logic                    fpga_cfg_done_pin,
  input wire logic [3:0]              step_code_pin,
  input wire fpled_pkg::fpled_src_t   src,
  input wire fpled_pkg::fpled_panel_t panel,
  input wire logic [3:0]              gen_led
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_reg;
  logic [2:0] own_reg;
  logic       usr_reg;
  logic [3:0] uval_reg;
  wire        ok = age_reg == 2'h3;
  wire        own = own_reg[2];
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_reg  <= 2'h0;
      own_reg  <= 3'h0;
      usr_reg  <= 1'h0;
      uval_reg <= 4'h0;
    end else begin
      if (!ok) age_reg <= age_reg + 2'h1;
      own_reg <= {own_reg[1:0], board_cfg_done_pin & fpga_cfg_done_pin};
      if (bus.wr && bus.addr == fpled_pkg::OFF_CTRL) begin
        usr_reg  <= bus.wdata[0];
        uval_reg <= bus.wdata[7:4];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_swap_level: assert property (ok &&
    ($past(swap_req_pin, 3) & 4'hC) == 4'h0 |->
    panel.hot_swap == ($past(swap_req_pin, 3) == fpled_pkg::FPLED_SWAP_ON))
    else $error("hot swap lamp wrong");
  a_fault_lamp: assert property (ok |-> panel.fault == $past(fault_pin, 3))
    else $error("fault lamp wrong");
  a_user_lamp: assert property (ok |->
    panel.user == $past(payload_pwr_pin & !fault_pin, 3))
    else $error("user lamp wrong");
  a_power_good: assert property (ok |->
    panel.power_good == $past(payload_pwr_pin & supplies_ok_pin, 3))
    else $error("power good lamp wrong");
  a_cfg_done: assert property (ok && $past(payload_pwr_pin &
    supplies_ok_pin & board_cfg_done_pin, 3) |-> panel.board_cfg)
    else $error("config lamp not lit");
  a_fpga_dark: assert property (ok && !$past(fpga_cfg_done_pin, 3)
    |-> !panel.fpga)
    else $error("fpga lamp lit");
  a_step_code: assert property (ok && !own |-> gen_led ==
    ($past(step_code_pin, 3) > 4'h9 ? 4'h0 : $past(step_code_pin, 3)))
    else $error("step code wrong");
  a_led1_busy: assert property (ok && own && !$past(usr_reg)
    |-> gen_led[0] == |$past(src.unit_busy))
    else $error("led1 wrong");
  a_led2_mem: assert property (ok && own && !$past(usr_reg)
    |-> gen_led[1] == &$past(src.mem_cal_ok))
    else $error("led2 wrong");
  a_led3_conv: assert property (ok && own && !$past(usr_reg)
    |-> gen_led[2] == &$past(src.conv_cal_ok))
    else $error("led3 wrong");
  a_led4_dead: assert property (ok && own && !$past(usr_reg) &&
    !$past(src.host_alive) |-> !gen_led[3])
    else $error("led4 lit without host");
  a_user_leds: assert property (ok && own && $past(usr_reg)
    |-> gen_led == $past(uval_reg))
    else $error("user leds wrong");
endmodule
bind fpled_top fpled_props fpled_props_i (.clk, .rst, .bus, .swap_req_pin,
  .fault_pin, .payload_pwr_pin, .supplies_ok_pin, .board_cfg_done_pin,
  .fpga_cfg_done_pin, .step_code_pin, .src, .panel, .gen_led);
`default_nettype wire

// [test/fpled_eye.sv]
/* operator watching the lamps: counts toggles since clr.
   assumes the same clock as the block. */
`default_nettype none
module fpled_eye (
  input  wire logic                    clk,
  input  wire logic                    clr,
  input  wire fpled_pkg::fpled_panel_t panel,
  input  wire logic [3:0]              gen_led,
  output var  logic [7:0]              n_swap,
  output var  logic [7:0]              n_cfg,
  output var  logic [7:0]              n_alv
);
  timeunit 1ns;
  timeprecision 1ps;
  fpled_pkg::fpled_panel_t p_reg;
  logic                    a_reg;
  always_ff @(posedge clk) begin
    p_reg <= panel;
    a_reg <= gen_led[3];
    if (clr) begin
      n_swap <= 8'h0;
      n_cfg <= 8'h0;
      n_alv <= 8'h0;
    end else begin
      n_swap <= n_swap + 8'(panel.hot_swap != p_reg.hot_swap);
      n_cfg <= n_cfg + 8'(panel.board_cfg != p_reg.board_cfg);
      n_alv <= n_alv + 8'(gen_led[3] != a_reg);
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
/* bench for fpled_top with small blink halves.
   assumes fpled_eye and the bound fpled_props. */
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  fpled_pkg::fpled_bus_t   bus = '0;
  logic [31:0]             rdata;
  fpled_pkg::fpled_swap_t  swap = fpled_pkg::FPLED_SWAP_OFF;
  logic                    flt = 1'b0, pwr = 1'b0, sok = 1'b0;
  logic                    bcd = 1'b0, fcd = 1'b0, clr = 1'b0;
  logic [3:0]              step = 4'h0;
  fpled_pkg::fpled_src_t   src = '0;
  fpled_pkg::fpled_panel_t panel;
  logic [3:0]              gen_led;
  logic [7:0]              n_swap, n_cfg, n_alv;
  int                      num_errors = 0, n_tests = 0, cyc = 0;
  fpled_top #(.SHORT_HALF(2), .LONG_HALF(8), .SLOW_HALF(16),
    .ALIVE_HALF(4)) fpled_top_i (.clk, .rst, .bus, .rdata,
    .swap_req_pin(swap), .fault_pin(flt), .payload_pwr_pin(pwr),
    .supplies_ok_pin(sok), .board_cfg_done_pin(bcd),
    .fpga_cfg_done_pin(fcd), .step_code_pin(step), .src, .panel, .gen_led);
  fpled_eye fpled_eye_i (.clk, .clr, .panel, .gen_led, .n_swap, .n_cfg,
    .n_alv);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic see(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic watch(int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    see(n);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata)
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(fpled_pkg::OFF_CTRL, 32'h0);
    rd(4'hC, 32'h0);
    wr(fpled_pkg::OFF_CTRL, 32'hFFFF_FFFF);
    rd(fpled_pkg::OFF_CTRL, 32'hF1);
    wr(fpled_pkg::OFF_CTRL, 32'h0);
    $display("done regs");
  endtask
  task automatic t_panel();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {flt, pwr, sok} <= 3'(i);
      see(4);
      `CHK("fault", flt, panel.fault)
      `CHK("user", pwr & !flt, panel.user)
      `CHK("power good", pwr & sok, panel.power_good)
      if (!pwr) `CHK("cfg off", 1'b0, panel.board_cfg)
    end
    $display("done panel");
  endtask
  task automatic t_swap();
    int lo[4] = '{0, 0, 15, 3};
    int hi[4] = '{0, 0, 17, 5};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      swap <= fpled_pkg::fpled_swap_t'(4'h1 << i);
      see(4);
      watch(32);
      `CHK("swap", 1'b1, n_swap >= lo[i] && n_swap <= hi[i])
      if (i < 2) `CHK("swap lit", i[0], panel.hot_swap)
    end
    $display("done hot swap");
  endtask
  task automatic t_step();
    for (int c = 0; c < 11; c++) begin
      @(posedge clk);
      step <= (c == 10) ? 4'hC : 4'(c);
      see(4);
      `CHK("step", (c == 10) ? 4'h0 : 4'(c), gen_led)
    end
    $display("done step");
  endtask
  task automatic t_cfg();
    @(posedge clk);
    flt <= 1'b0;
    watch(64);
    `CHK("cfg blink", 1'b1, n_cfg >= 3 && n_cfg <= 5)
    `CHK("fpga off", 1'b0, panel.fpga)
    @(posedge clk);
    bcd <= 1'b1;
    see(4);
    `CHK("cfg on", 1'b1, panel.board_cfg)
    `CHK("step kept", 4'h0, gen_led)
    @(posedge clk);
    fcd <= 1'b1;
    see(4);
    `CHK("fpga on", 1'b1, panel.fpga)
    $display("done config");
  endtask
  task automatic t_status();
    fpled_pkg::fpled_src_t s[4] = '{{4'h1, 2'h1, 4'hF, 1'b0},
      {4'h8, 2'h3, 4'h7, 1'b0}, {4'h0, 2'h2, 4'hE, 1'b0},
      {4'h0, 2'h3, 4'hF, 1'b0}};
    logic [2:0] e[4] = '{3'h5, 3'h3, 3'h0, 3'h6};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src <= s[i];
      see(2);
      `CHK("status", e[i], gen_led[2:0])
      `CHK("alive off", 1'b0, gen_led[3])
    end
    `CHK("cal ready", 2'h3, gen_led[2:1])
    @(posedge clk);
    src.host_alive <= 1'b1;
    watch(32);
    `CHK("alive", 1'b1, n_alv >= 7 && n_alv <= 9)
    $display("done status");
  endtask
  task automatic t_user();
    wr(fpled_pkg::OFF_CTRL, 32'h51);
    see(1);
    `CHK("user leds", 4'h5, gen_led)
    rd(fpled_pkg::OFF_LEDS, 32'h15);
    wr(fpled_pkg::OFF_CTRL, 32'h0);
    see(1);
    `CHK("status back", 3'h6, gen_led[2:0])
    @(posedge clk);
    swap <= fpled_pkg::FPLED_SWAP_ON;
    wr(fpled_pkg::OFF_CTRL, 32'h51);
    see(4);
    rd(fpled_pkg::OFF_STATUS, 32'h2F);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(fpled_pkg::OFF_CTRL, 32'h0);
    see(4);
    `CHK("status reset", 3'h6, gen_led[2:0])
    $display("done user");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_panel();
    t_swap();
    t_step();
    t_cfg();
    t_status();
    t_user();
    summarize();
  end
endmodule
`default_nettype wire
